// [pcm_pkg.sv]
// How it works
// (RULE_01) Status bit 0 shows processor clock running.
// (RULE_02) Status bit 7 shows USB port clock running.
// (RULE_03) Status bits 8 to 11 show programmable outputs.
// (RULE_04) Writing one to set register enables gate.
// (RULE_05) Writing one to clear register disables gate.
// (RULE_06) Gate status reads one per enabled peripheral.
// (RULE_07) Unimplemented peripheral bits change nothing at all.
// (RULE_08) Oscillator enable starts wait, then stable flag.
// (RULE_09) Software never sets enable and bypass together.
// (RULE_10) Bypass sets the stable flag without waiting.
// (RULE_11) Clearing enable and bypass clears stable flag.
// (RULE_12) Start-up wait is count times eight slow cycles.
// (RULE_13) Measure main cycles over sixteen slow periods.
// (RULE_14) Measure valid only after oscillator on, done.
// (RULE_15) PLL divider: zero off, one bypass, else divide.
// (RULE_16) PLL write waits settle count slow cycles.
// (RULE_17) Multiplier zero stops PLL, else times factor+1; the code's PLL tick ignores the factor.
// (RULE_18) USB ratio divides PLL by one, two, four.
// (RULE_19) Source select: slow, main, PLL; ten reserved.
// (RULE_20) Software programs PLL range field to match.
// (RULE_21) Master ratio divides by powers of two.
// (RULE_22) Settled flag reads one once PLL locked.
// (RULE_23) Master ready reads zero during a change.
// (RULE_24) PLL write clears settled flag, restarts counter.
// (RULE_25) Read-only writes ignored; write-only reads zero.
package pcm_pkg;
  // Register byte offsets on the local register port.
  localparam logic [7:0] OFS_SYS_SET   = 8'h00; // System clock enable.
  localparam logic [7:0] OFS_SYS_CLR   = 8'h04; // System clock disable.
  localparam logic [7:0] OFS_SYS_STATE = 8'h08; // System clock status.
  localparam logic [7:0] OFS_GATE_SET  = 8'h10; // Peripheral gate set.
  localparam logic [7:0] OFS_GATE_CLR  = 8'h14; // Peripheral gate clear.
  localparam logic [7:0] OFS_GATE_ST   = 8'h18; // Peripheral gate status.
  localparam logic [7:0] OFS_OSC_CTRL  = 8'h20; // Main oscillator control.
  localparam logic [7:0] OFS_MEASURE   = 8'h24; // Frequency measurement.
  localparam logic [7:0] OFS_PLL_CTRL  = 8'h2C; // PLL control.
  localparam logic [7:0] OFS_MCK_CTRL  = 8'h30; // Master clock control.
  localparam logic [7:0] OFS_FLAGS     = 8'h68; // Clock status flags.
  // System clock status fields.
  localparam int SYS_PROC_BIT  = 0;
  localparam int SYS_USB_BIT   = 7;
  localparam int SYS_PROG_LSB  = 8;
  localparam int SYS_PROG_N    = 4;
  // Oscillator control fields.
  localparam int OSC_ON_BIT    = 0;
  localparam int OSC_SKIP_BIT  = 1;
  localparam int OSC_CNT_LSB   = 8;
  localparam int OSC_CNT_MULT  = 8;   // Slow cycles per count step.
  // Measurement fields.
  localparam int MEAS_VALID_BIT = 16;
  localparam int MEAS_WINDOW    = 16; // Slow periods per measurement.
  // PLL control fields.
  localparam int PLL_DIV_LSB   = 0;
  localparam int PLL_CNT_LSB   = 8;
  localparam int PLL_RANGE_LSB = 14;
  localparam int PLL_MUL_LSB   = 16;
  localparam int PLL_USB_LSB   = 28;
  // Master clock control fields.
  localparam int MCK_SRC_LSB   = 0;
  localparam int MCK_MASTER_CLOCK_RATIO_LSB  = 2;
  // Status flag positions.
  localparam int FLG_OSC_BIT   = 0;
  localparam int FLG_LOCK_BIT  = 2;
  localparam int FLG_MCK_BIT   = 3;
  // Reset values.
  localparam logic [31:0] RST_PLL_CTRL  = 32'h0000_3F00;
  localparam logic [31:0] RST_PERIPH_OK = 32'hFFFF_FFFC;
  // Master clock source codes.
  typedef enum logic [1:0] {
    SRC_SLOW = 2'h0,
    SRC_MAIN = 2'h1,
    SRC_RSVD = 2'h2,
    SRC_PLL  = 2'h3
  } pcm_src_t;
  // Measurement sequencer states.
  typedef enum logic [2:0] {
    MS_IDLE = 3'b001,
    MS_RUN  = 3'b010,
    MS_DONE = 3'b100
  } pcm_meas_t;
endpackage : pcm_pkg

// [pcm_edge_sync.sv]
// Brings an outside clock pin into the system domain through two
// flip-flops and gives a one-cycle pulse on each rising edge.
module pcm_edge_sync (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst_n,
  // Outside level and edge pulse.
  input  wire logic pin,
  output logic      rise
);
  import pcm_pkg::*;
  logic meta_r; // First stage, read only by the second.
  logic sync_r; // Second stage, safe to use.
  logic last_r; // Previous synchronised level.

  // Shift the pin through the synchroniser and keep one old copy.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  // A rising edge is a new high after a low.
  assign rise = sync_r & ~last_r;
endmodule : pcm_edge_sync

// [pcm_wait_timer.sv]
// Counts down a loaded number of ticks and reports when it is done.
module pcm_wait_timer #(
  parameter int W = 12
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Load, tick and result.
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  input  wire logic         tick,
  output logic              done
);
  import pcm_pkg::*;
  logic [W-1:0] cnt_r;  // Ticks still to wait.
  logic         done_r; // Wait has elapsed.

  // A load restarts the wait; a zero value ends it at once.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r  <= '0;
      done_r <= 1'b0;
    end else if (load) begin
      cnt_r  <= value;
      done_r <= (value == '0);
    end else if (tick && !done_r) begin
      cnt_r  <= cnt_r - W'(1);
      done_r <= (cnt_r == W'(1));
    end
  end

  assign done = done_r;
endmodule : pcm_wait_timer

// [pcm_top.sv]
// Power and clock manager register block with oscillator, PLL lock,
// measurement and master clock enable generation.
module pcm_top #(
  parameter logic [31:0] PERIPH_OK = pcm_pkg::RST_PERIPH_OK
) (
  // System clock and reset.
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  // Register port.
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WR_DATA,
  input  wire logic        WR_EN,
  input  wire logic        RD_EN,
  output logic [31:0]      RD_DATA,
  // Outside clock pins, sampled into this domain.
  input  wire logic        SLOW_CLK,
  input  wire logic        MAIN_CLK,
  // Gate enables.
  output logic             PROC_CLK_EN,
  output logic             USB_CLK_EN,
  output logic [3:0]       PROG_CLK_EN,
  output logic [31:0]      PERIPH_CLK_EN,
  // Oscillator and PLL controls.
  output logic             OSC_EN,
  output logic             OSC_BYPASS,
  output logic [7:0]       PLL_DIV,
  output logic [10:0]      PLL_MUL,
  output logic [1:0]       USB_DIV,
  // Master clock enable pulse and its setting.
  output logic [1:0]       MCK_SRC,
  output logic [2:0]       MCK_MASTER_CLOCK_RATIO,
  output logic             MCK_TICK
);
  import pcm_pkg::*;

  // Reset release synchroniser.
  logic rst_m_r;               // First reset stage.
  logic rst_n_r;               // Released reset used everywhere.
  // Software state.
  logic        proc_on_r;      // Processor clock running.
  logic        usb_on_r;       // USB port clock running.
  logic [3:0]  prog_on_r;      // Programmable outputs enabled.
  logic [31:0] gate_r;         // Peripheral gates.
  logic [31:0] osc_ctrl_r;     // Oscillator control word.
  logic [31:0] pll_ctrl_r;     // PLL control word.
  logic [4:0]  mck_ctrl_r;     // Master clock control field.
  logic [31:0] rd_data_r;      // Read answer.
  // Hardware state.
  logic        osc_stable_r;   // Oscillator stable flag.
  logic        mck_ready_r;    // Master clock ready flag.
  logic        mck_tick_r;     // Master clock enable pulse.
  logic [6:0]  master_clock_ratio_cnt_r;     // Master prescaler counter.
  logic [7:0]  pll_div_cnt_r;  // PLL input divider counter.
  logic        osc_seen_r;     // Oscillator on since enabled.
  pcm_meas_t   meas_st_r;      // Measurement sequencer state.
  logic [4:0]  meas_win_r;     // Slow periods counted so far.
  logic [15:0] meas_cnt_r;     // Main edges in current window.
  logic [15:0] meas_res_r;     // Latched measurement result.
  logic        meas_valid_r;   // Result valid.

  // Decoded strobes.
  wire wr_sys_set  = WR_EN && (ADDR == OFS_SYS_SET);
  wire wr_sys_clr  = WR_EN && (ADDR == OFS_SYS_CLR);
  wire wr_gate_set = WR_EN && (ADDR == OFS_GATE_SET);
  wire wr_gate_clr = WR_EN && (ADDR == OFS_GATE_CLR);
  wire wr_osc      = WR_EN && (ADDR == OFS_OSC_CTRL);
  wire wr_pll      = WR_EN && (ADDR == OFS_PLL_CTRL);
  wire wr_mck      = WR_EN && (ADDR == OFS_MCK_CTRL);

  // Named fields of the control words.
  wire        osc_on   = osc_ctrl_r[OSC_ON_BIT];
  wire        osc_skip = osc_ctrl_r[OSC_SKIP_BIT];
  wire [7:0]  pll_div  = pll_ctrl_r[PLL_DIV_LSB +: 8];
  wire [10:0] pll_mul  = pll_ctrl_r[PLL_MUL_LSB +: 11];
  wire [1:0]  mck_src  = mck_ctrl_r[1:0];
  wire [2:0]  mck_master_clock_ratio = mck_ctrl_r[4:2];

  // Edge pulses from the outside clock pins, and the two wait results.
  wire slow_tick;
  wire main_tick;
  wire osc_done;
  wire pll_lock;

  pcm_edge_sync u_slow (
    .clk   (SYS_CLK),
    .rst_n (rst_n_r),
    .pin   (SLOW_CLK),
    .rise  (slow_tick)
  );

  pcm_edge_sync u_main (
    .clk   (SYS_CLK),
    .rst_n (rst_n_r),
    .pin   (MAIN_CLK),
    .rise  (main_tick)
  );

  // Oscillator wait restarts on each control write, eight slow cycles
  // per count step.
  pcm_wait_timer #(.W(12)) u_osc_wait (
    .clk   (SYS_CLK),
    .rst_n (rst_n_r),
    .load  (wr_osc),
    .value (12'(WR_DATA[OSC_CNT_LSB +: 8]) * 12'(OSC_CNT_MULT)), // RULE_12
    .tick  (slow_tick),
    .done  (osc_done)
  );

  // Any PLL write restarts the lock wait from the new count.
  pcm_wait_timer #(.W(6)) u_pll_wait (
    .clk   (SYS_CLK),
    .rst_n (rst_n_r),
    .load  (wr_pll),                             // RULE_24
    .value (WR_DATA[PLL_CNT_LSB +: 6]),          // RULE_16
    .tick  (slow_tick),
    .done  (pll_lock)                            // RULE_22
  );

  // The PLL runs only with a nonzero multiplier and a live divider.
  wire pll_run = (pll_mul != 11'h000) && (pll_div != 8'h00)   // RULE_17
                 && pll_lock;                                  // RULE_15
  // Input divider: code one passes every cycle, higher codes divide.
  wire pll_tick = pll_run && ((pll_div == 8'h01) ||
                  (pll_div_cnt_r == pll_div - 8'h01));         // RULE_15

  // Master source selection; the reserved code gives no clock.
  wire src_tick = (mck_src == SRC_SLOW) ? slow_tick :
                  (mck_src == SRC_MAIN) ? (main_tick && osc_stable_r) :
                  (mck_src == SRC_PLL)  ? pll_tick : 1'b0;     // RULE_19
  // Prescaler end count for divide by two to the code.
  wire [6:0] master_clock_ratio_end = 7'((8'h01 << mck_master_clock_ratio) - 8'h01);      // RULE_21
  wire mck_fire = src_tick && (mck_master_clock_ratio != 3'h7) &&
                  (master_clock_ratio_cnt_r == master_clock_ratio_end);                    // RULE_21

  // Read data selection; write-only and unmapped offsets give zero.
  wire [31:0] sys_state = {20'h0, prog_on_r, usb_on_r, 6'h0,
                           proc_on_r};          // RULE_01 RULE_02 RULE_03
  wire [31:0] flags     = {28'h0, mck_ready_r, pll_lock, 1'b0,
                           osc_stable_r};                      // RULE_22
  wire [31:0] rd_mux =
    (ADDR == OFS_SYS_STATE) ? sys_state :
    (ADDR == OFS_GATE_ST)   ? (gate_r & PERIPH_OK) :           // RULE_06
    (ADDR == OFS_OSC_CTRL)  ? osc_ctrl_r :
    (ADDR == OFS_MEASURE)   ? {15'h0, meas_valid_r, meas_res_r} :
    (ADDR == OFS_PLL_CTRL)  ? pll_ctrl_r :
    (ADDR == OFS_MCK_CTRL)  ? {27'h0, mck_ctrl_r} :
    (ADDR == OFS_FLAGS)     ? flags : 32'h0;                   // RULE_25

  // Reset is released through two flip-flops.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_m_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_n_r <= rst_m_r;
    end
  end

  // System clock gates: set and clear registers, ones act except the processor bit on set.
  always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      proc_on_r <= 1'b1;
      usb_on_r  <= 1'b0;
      prog_on_r <= 4'h0;
    end else if (wr_sys_set) begin
      usb_on_r  <= usb_on_r | WR_DATA[SYS_USB_BIT];            // RULE_02
      prog_on_r <= prog_on_r | WR_DATA[SYS_PROG_LSB +: 4];     // RULE_03
    end else if (wr_sys_clr) begin
      proc_on_r <= proc_on_r & ~WR_DATA[SYS_PROC_BIT];         // RULE_01
      usb_on_r  <= usb_on_r & ~WR_DATA[SYS_USB_BIT];           // RULE_02
      prog_on_r <= prog_on_r & ~WR_DATA[SYS_PROG_LSB +: 4];    // RULE_03
    end
  end

  // Peripheral gates; bits of missing identifiers never store.
  always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      gate_r <= 32'h0;
    end else if (wr_gate_set) begin
      gate_r <= gate_r | (WR_DATA & PERIPH_OK);         // RULE_04 RULE_07
    end else if (wr_gate_clr) begin
      gate_r <= gate_r & ~(WR_DATA & PERIPH_OK);        // RULE_05 RULE_07
    end
  end

  // Read-write control words; status offsets take no write.
  always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      osc_ctrl_r <= 32'h0;
      pll_ctrl_r <= RST_PLL_CTRL;
      mck_ctrl_r <= 5'h00;
    end else begin
      if (wr_osc) begin
        osc_ctrl_r <= WR_DATA & 32'h0000_FF03;
      end
      if (wr_pll) begin
        pll_ctrl_r <= WR_DATA & 32'h37FF_FFFF;
      end
      if (wr_mck) begin
        mck_ctrl_r <= WR_DATA[MCK_SRC_LSB +: 5];
      end
    end
  end

  // Stable flag: bypass at once, enable after the wait, else clear.
  always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      osc_stable_r <= 1'b0;
    end else begin
      osc_stable_r <= osc_skip ||                              // RULE_10
                      (osc_on && osc_done && !wr_osc);  // RULE_08 RULE_11
    end
  end

  // PLL input divider counter, cleared while the PLL is off.
  always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pll_div_cnt_r <= 8'h00;
    end else if (!pll_run || pll_tick) begin
      pll_div_cnt_r <= 8'h00;
    end else begin
      pll_div_cnt_r <= pll_div_cnt_r + 8'h01;
    end
  end

  // Master prescaler; a control write drops ready until a new tick.
  always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      master_clock_ratio_cnt_r  <= 7'h00;
      mck_tick_r  <= 1'b0;
      mck_ready_r <= 1'b1;
    end else if (wr_mck) begin
      master_clock_ratio_cnt_r  <= 7'h00;
      mck_tick_r  <= 1'b0;
      mck_ready_r <= 1'b0;                                     // RULE_23
    end else begin
      mck_tick_r <= mck_fire;
      if (mck_fire) begin
        master_clock_ratio_cnt_r  <= 7'h00;
        mck_ready_r <= 1'b1;                                   // RULE_23
      end else if (src_tick) begin
        master_clock_ratio_cnt_r <= master_clock_ratio_cnt_r + 7'h01;
      end
    end
  end

  // Measurement sequencer: waits for a slow edge, counts main edges
  // for sixteen slow periods, then latches the result.
  always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      meas_st_r    <= MS_IDLE;
      meas_win_r   <= 5'h00;
      meas_cnt_r   <= 16'h0000;
      meas_res_r   <= 16'h0000;
      meas_valid_r <= 1'b0;
      osc_seen_r   <= 1'b0;
    end else if (!osc_on && !osc_skip) begin
      meas_st_r    <= MS_IDLE;
      meas_valid_r <= 1'b0;                                    // RULE_14
      osc_seen_r   <= 1'b0;
    end else begin
      osc_seen_r <= 1'b1;
      case (meas_st_r)
        MS_IDLE: begin
          meas_win_r <= 5'h00;
          meas_cnt_r <= 16'h0000;
          if (slow_tick && osc_seen_r) begin
            meas_st_r <= MS_RUN;
          end
        end
        MS_RUN: begin
          if (main_tick) begin
            meas_cnt_r <= meas_cnt_r + 16'h0001;               // RULE_13
          end
          if (slow_tick) begin
            meas_win_r <= meas_win_r + 5'h01;
            if (meas_win_r == 5'(MEAS_WINDOW - 1)) begin       // RULE_13
              meas_st_r <= MS_DONE;
            end
          end
        end
        MS_DONE: begin
          meas_res_r   <= meas_cnt_r;
          meas_valid_r <= 1'b1;                                // RULE_14
        end
        default: begin
          meas_st_r <= MS_IDLE;
        end
      endcase
    end
  end

  // Read answer stands in the cycle after the strobe only.
  always_ff @(posedge SYS_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rd_data_r <= 32'h0;
    end else begin
      rd_data_r <= RD_EN ? rd_mux : 32'h0;                     // RULE_25
    end
  end

  // Outputs, each straight from a flip-flop.
  assign RD_DATA       = rd_data_r;
  assign PROC_CLK_EN   = proc_on_r;
  assign USB_CLK_EN    = usb_on_r;
  assign PROG_CLK_EN   = prog_on_r;
  assign PERIPH_CLK_EN = gate_r;
  assign OSC_EN        = osc_ctrl_r[OSC_ON_BIT];
  assign OSC_BYPASS    = osc_ctrl_r[OSC_SKIP_BIT];
  assign PLL_DIV       = pll_ctrl_r[PLL_DIV_LSB +: 8];
  assign PLL_MUL       = pll_ctrl_r[PLL_MUL_LSB +: 11];
  assign USB_DIV       = pll_ctrl_r[PLL_USB_LSB +: 2];         // RULE_18
  assign MCK_SRC       = mck_ctrl_r[1:0];
  assign MCK_MASTER_CLOCK_RATIO      = mck_ctrl_r[4:2];
  assign MCK_TICK      = mck_tick_r;

  // Checks of the block's own behaviour.
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!rst_n_r);

  sequence sq_skip_write;
    wr_osc && WR_DATA[OSC_SKIP_BIT];
  endsequence
  sequence sq_all_off_write;
    wr_osc && !WR_DATA[OSC_SKIP_BIT] && !WR_DATA[OSC_ON_BIT];
  endsequence
  // A PLL write whose count cannot elapse within two cycles.
  sequence sq_pll_slow_write;
    wr_pll && (WR_DATA[PLL_CNT_LSB +: 6] > 6'h01);
  endsequence

  proc_status_a: assert property ( // RULE_01
    RD_EN && ADDR == OFS_SYS_STATE |=> RD_DATA[0] == PROC_CLK_EN)
    else $error("processor clock status bit wrong");
  usb_status_a: assert property ( // RULE_02
    RD_EN && ADDR == OFS_SYS_STATE |=> RD_DATA[7] == USB_CLK_EN)
    else $error("usb clock status bit wrong");
  gate_set_a: assert property ( // RULE_04
    wr_gate_set |=> PERIPH_CLK_EN ==
      ($past(PERIPH_CLK_EN) | ($past(WR_DATA) & PERIPH_OK)))
    else $error("gate set write wrong");
  gate_clr_a: assert property ( // RULE_05
    wr_gate_clr |=> (PERIPH_CLK_EN & $past(WR_DATA) & PERIPH_OK) == 0)
    else $error("gate clear write wrong");
  gate_read_a: assert property ( // RULE_06
    RD_EN && ADDR == OFS_GATE_ST |=> RD_DATA == (gate_r & PERIPH_OK))
    else $error("gate status read wrong");
  skip_stable_a: assert property ( // RULE_10
    sq_skip_write |=> ##1 osc_stable_r)
    else $error("bypass did not set stable flag");
  osc_off_a: assert property ( // RULE_11
    sq_all_off_write ##1 !wr_osc |=> !osc_stable_r [*2])
    else $error("stable flag not cleared");
  pll_restart_a: assert property ( // RULE_24
    sq_pll_slow_write |=> !pll_lock ##1
      ($past(wr_pll) || !flags[FLG_LOCK_BIT]))
    else $error("pll write did not clear lock");
  wo_read_a: assert property ( // RULE_25
    RD_EN && (ADDR == OFS_GATE_SET || ADDR == OFS_SYS_CLR)
      |=> RD_DATA == 32'h0)
    else $error("write-only register read not zero");
  meas_off_a: assert property ( // RULE_14
    !osc_on && !osc_skip |=> !meas_valid_r)
    else $error("measure valid with oscillator off");
  mck_change_a: assert property ( // RULE_23
    wr_mck |=> !mck_ready_r && !MCK_TICK)
    else $error("master ready not dropped");
endmodule : pcm_top

// [power_clock_manager_regs_tb.sv]
module power_clock_manager_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pcm_pkg::*;
  // Bench drives and design outputs.
  logic        SYS_CLK, RST_N, WR_EN, RD_EN, SLOW_CLK, MAIN_CLK;
  logic [7:0]  ADDR, PLL_DIV;
  logic [31:0] WR_DATA, RD_DATA, PERIPH_CLK_EN, got;
  logic        PROC_CLK_EN, USB_CLK_EN, OSC_EN, OSC_BYPASS, MCK_TICK;
  logic [3:0]  PROG_CLK_EN;
  logic [10:0] PLL_MUL;
  logic [1:0]  USB_DIV, MCK_SRC;
  logic [2:0]  MCK_MASTER_CLOCK_RATIO;
  int          fails, samples_checked, cyc;
  // Master tick table: source, ratio code, expected spacing (0 = none).
  int          t_src[6] = '{3, 1, 0, 0, 2, 3};
  int          t_pre[6] = '{1, 0, 2, 7, 0, 6};
  int          t_gap[6] = '{8, 4, 40, 0, 0, 256};

  pcm_top u_pcm_top (.SYS_CLK, .RST_N, .ADDR, .WR_DATA, .WR_EN, .RD_EN,
    .RD_DATA, .SLOW_CLK, .MAIN_CLK, .PROC_CLK_EN, .USB_CLK_EN,
    .PROG_CLK_EN, .PERIPH_CLK_EN, .OSC_EN, .OSC_BYPASS, .PLL_DIV,
    .PLL_MUL, .USB_DIV, .MCK_SRC, .MCK_MASTER_CLOCK_RATIO, .MCK_TICK);

  // System clock at 20 MHz.
  initial begin
    SYS_CLK = 1'b0;
    forever #25 SYS_CLK = ~SYS_CLK;
  end

  // Slow clock is ten system cycles, main clock four, never rising together
  // so the measured count has no boundary ambiguity; also the hang guard.
  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    SLOW_CLK <= (cyc % 10) < 5;
    MAIN_CLK <= ((cyc + 1) % 4) < 2;
    if (cyc == 8000) begin
      fails++;
      $display("mismatch at %0t: timeout", $time);
      give_verdict();
    end
  end

  // Compares one value and counts the outcome.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge SYS_CLK);
  endtask : idle

  // One-cycle write strobe; returns mid-cycle so that outputs launched
  // by the write edge have settled before anyone looks at them.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    ADDR <= a;
    WR_DATA <= d;
    WR_EN <= 1'b1;
    @(posedge SYS_CLK);
    WR_EN <= 1'b0;
    @(negedge SYS_CLK);
  endtask : wr

  // One-cycle read strobe; data is taken in the following cycle only.
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    @(posedge SYS_CLK);
    ADDR <= a;
    RD_EN <= 1'b1;
    @(posedge SYS_CLK);
    RD_EN <= 1'b0;
    @(negedge SYS_CLK);
    got = RD_DATA;
    chk(got & m, e);
  endtask : rd

  // Waits for a master tick, then measures the distance to the next one; with zero expected, checks that no tick comes in 300 cycles.
  task automatic gap(input int e);
    int n;
    n = 0;
    @(negedge SYS_CLK);
    while (MCK_TICK !== 1'b1 && n < 300) begin
      @(negedge SYS_CLK);
      n++;
    end
    if (e != 0) begin
      n = 0;
      do begin
        @(negedge SYS_CLK);
        n++;
      end while (MCK_TICK !== 1'b1 && n < 300);
    end
    chk(n, (e == 0) ? 300 : e);
  endtask : gap

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    {RST_N, WR_EN, RD_EN} = '0;
    {ADDR, WR_DATA} = '0;
    {fails, samples_checked} = '0;
    idle(5);
    RST_N <= 1'b1;
    idle(5);
    // Reset contents and an unmapped read.
    rd(OFS_SYS_STATE, 32'h1, '1);
    rd(OFS_GATE_ST, 32'h0, '1);
    rd(OFS_PLL_CTRL, RST_PLL_CTRL, '1);
    rd(OFS_MCK_CTRL, 32'h0, '1);
    rd(OFS_FLAGS, 32'h8, 32'h8);
    rd(8'h7C, 32'h0, '1);
    $display("test reset done");
    // System clock gates.
    wr(OFS_SYS_SET, 32'h0000_0F81);
    rd(OFS_SYS_STATE, 32'h0000_0F81, '1);
    chk({USB_CLK_EN, PROG_CLK_EN}, 32'h1F);
    wr(OFS_SYS_CLR, 32'h0000_0281);
    rd(OFS_SYS_STATE, 32'h0000_0D00, '1);
    chk({PROC_CLK_EN, USB_CLK_EN, PROG_CLK_EN}, 32'h0D);
    rd(OFS_SYS_SET, 32'h0, '1);
    $display("test system done");
    // Peripheral gates, unimplemented bits and ignored writes.
    wr(OFS_GATE_SET, 32'hFFFF_FFFF);
    rd(OFS_GATE_ST, RST_PERIPH_OK, '1);
    wr(OFS_GATE_CLR, 32'h0000_0111);
    wr(OFS_GATE_SET, 32'h0);
    wr(OFS_GATE_ST, 32'h0);
    rd(OFS_GATE_ST, 32'hFFFF_FEEC, '1);
    chk(PERIPH_CLK_EN, 32'hFFFF_FEEC);
    rd(OFS_GATE_CLR, 32'h0, '1);
    $display("test gates done");
    // Oscillator bypass, off, then enable with a start-up count of 2.
    wr(OFS_OSC_CTRL, 32'h2);
    rd(OFS_FLAGS, 32'h1, 32'h1);
    wr(OFS_OSC_CTRL, 32'h0);
    rd(OFS_FLAGS, 32'h0, 32'h1);
    wr(OFS_OSC_CTRL, 32'h0000_0201);
    chk({OSC_EN, OSC_BYPASS}, 32'h2);
    idle(135);
    rd(OFS_FLAGS, 32'h0, 32'h1);
    idle(45);
    rd(OFS_FLAGS, 32'h1, 32'h1);
    rd(OFS_OSC_CTRL, 32'h0000_0201, '1);
    idle(30);
    wr(OFS_MEASURE, 32'h0);
    rd(OFS_MEASURE, 32'h10000 | (MEAS_WINDOW * 10 / 4), '1);
    $display("test oscillator done");
    // PLL fields and lock counter of 3 slow cycles.
    wr(OFS_PLL_CTRL, 32'h1005_0304);
    rd(OFS_FLAGS, 32'h0, 32'h4);
    chk({PLL_DIV, PLL_MUL, USB_DIV}, {11'h0, 8'h4, 11'h5, 2'h1});
    idle(50);
    rd(OFS_FLAGS, 32'h4, 32'h4);
    rd(OFS_PLL_CTRL, 32'h1005_0304, '1);
    $display("test pll done");
    // Master clock sources and ratios.
    for (int i = 0; i < 6; i++) begin
      wr(OFS_MCK_CTRL, t_src[i] | (t_pre[i] << MCK_MASTER_CLOCK_RATIO_LSB));
      chk({MCK_SRC, MCK_MASTER_CLOCK_RATIO}, t_src[i] * 8 + t_pre[i]);
      gap(t_gap[i]);
      rd(OFS_FLAGS, (t_gap[i] != 0) ? 32'h8 : 32'h0, 32'h8);
    end
    $display("test master done");
    // PLL input divider bypass, then stopped, seen on the master tick.
    wr(OFS_PLL_CTRL, 32'h0005_0001);
    gap(64);
    wr(OFS_PLL_CTRL, 32'h0005_0000);
    idle(2);
    gap(0);
    $display("test divider done");
    // Oscillator off invalidates the measurement.
    wr(OFS_OSC_CTRL, 32'h0);
    rd(OFS_MEASURE, 32'h0, 32'h10000);
    $display("test measure off done");
    give_verdict();
  end
endmodule : power_clock_manager_regs_tb
